// ==== shared/spe_pkg.sv ====
`default_nettype none

package spe_pkg;

  // Status vector bit positions
  localparam int unsigned ST_W   = 6;
  localparam int unsigned ST_HBF = 0;
  localparam int unsigned ST_HBD = 1;
  localparam int unsigned ST_IF  = 2;
  localparam int unsigned ST_INF = 3;
  localparam int unsigned ST_PM  = 4;
  localparam int unsigned ST_TFE = 5;
  localparam logic [5:0]  ST_RST = 6'h00;

  // Link error register bit positions
  localparam int unsigned LE_W   = 4;
  localparam int unsigned LE_P   = 0;
  localparam int unsigned LE_C   = 1;
  localparam int unsigned LE_H   = 2;
  localparam int unsigned LE_B   = 3;
  localparam logic [3:0]  LE_RST = 4'h0;

  // Unknown frame types above this length are illegal
  localparam logic [13:0] UNK_MAX_LEN = 14'h0040;

  // Memory error source codes
  localparam logic [2:0] MSRC_CMD_LIST = 3'h0;
  localparam logic [2:0] MSRC_CMD_FRM  = 3'h1;
  localparam logic [2:0] MSRC_SG_ENTRY = 3'h2;
  localparam logic [2:0] MSRC_DATA     = 3'h3;
  localparam logic [2:0] MSRC_ATAPI    = 3'h4;

  localparam logic [3:0]  DRIVE_RST = 4'h0;
  localparam logic [31:0] SACT_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    SPE_ABT_IDLE = 2'b00,
    SPE_ABT_WAIT = 2'b01,
    SPE_ABT_SET  = 2'b11
  } spe_abt_e;

  typedef enum logic [1:0] {
    SPE_RT_IDLE = 2'b00,
    SPE_RT_HOLD = 2'b01,
    SPE_RT_SENT = 2'b11
  } spe_rt_e;

  // {fatal, nonfatal} by frame kind
  function automatic logic [1:0] spe_classify(input logic in_data);
    return in_data ? 2'b10 : 2'b01;
  endfunction : spe_classify

endpackage : spe_pkg

`default_nettype wire

// ==== rtl/spe_retry_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none

module spe_retry_ctl
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_port_start,
  input  wire logic i_fail_nondata,
  input  wire logic i_tx_ok,
  input  wire logic i_rx_busy,
  output logic      o_retry,
  output logic      o_pending
);

  spe_pkg::spe_rt_e state_reg;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      state_reg <= spe_pkg::SPE_RT_IDLE;
    else if (!i_port_start)
      state_reg <= spe_pkg::SPE_RT_IDLE; // [RULE9]
    else
    begin
      case (state_reg)
        spe_pkg::SPE_RT_IDLE:
          if (i_fail_nondata)
            state_reg <= spe_pkg::SPE_RT_HOLD;
        // Incoming frames are served before the resend
        spe_pkg::SPE_RT_HOLD:
          if (!i_rx_busy)
            state_reg <= spe_pkg::SPE_RT_SENT; // [RULE8]
        spe_pkg::SPE_RT_SENT:
          if (i_fail_nondata)
            state_reg <= spe_pkg::SPE_RT_HOLD; // [RULE9]
          else if (i_tx_ok)
            state_reg <= spe_pkg::SPE_RT_IDLE;
        default:
          state_reg <= spe_pkg::SPE_RT_IDLE;
      endcase
    end
  end

  assign o_retry = (state_reg == spe_pkg::SPE_RT_HOLD) && !i_rx_busy && i_port_start;
  assign o_pending = (state_reg != spe_pkg::SPE_RT_IDLE);

  property p_no_retry_busy;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_rx_busy |-> !o_retry;
  endproperty
  a_no_retry_busy: assert property (p_no_retry_busy) else $error("retry during receive"); // [RULE8]

  property p_retry_follows;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_fail_nondata && i_port_start && state_reg != spe_pkg::SPE_RT_HOLD) ##1
      (!i_rx_busy && i_port_start) |-> o_retry;
  endproperty
  a_retry_follows: assert property (p_retry_follows) else $error("failed frame not resent"); // [RULE9]

endmodule : spe_retry_ctl

`default_nettype wire

// ==== rtl/spe_err_classifier.sv ====
`timescale 1ns/100ps
`default_nettype none

// Contract
// (RULE1) Abort: end transfer, then host fatal status
// (RULE2) Host fatal interrupt needs both enables
// (RULE3) Fetch data error stops the port
// (RULE4) Continuing after data error poisons CRC
// (RULE5) Data error: end transfer, set status
// (RULE6) P, C, H or link drop flag interface
// (RULE7) Data frame fatal, otherwise non-fatal
// (RULE8) Serve incoming frames before resending
// (RULE9) Resend non-Data until success or stop
// (RULE10) Control disparity: reset decoder, no bits
// (RULE11) Decode error: R_ERR, decode bit only
// (RULE12) Link drop: idle; outside frame, no status
// (RULE13) Bad CRC: R_ERR, idle, CRC bit
// (RULE14) Illegal frame: R_ERR, no post, P bit
// (RULE15) Receive overflow: R_ERR, P bit
// (RULE16) Drive R_ERR on transmit: handshake bit
// (RULE17) Busy/request already clear: ignore frame
// (RULE18) Post non-Data only after validation
// (RULE19) Wrong multiplier port: R_OK, discard, status
// (RULE20) Taskfile error with enable: interrupt, stop
// (RULE21) Device-bits error: tags, status, drive record
// (RULE22) Register/setup error: status, halt or record
// (RULE23) Interrupt while enabled status bit set
module spe_err_classifier
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_port_start_bit,
  input  wire logic        i_global_interrupt_enable,
  input  wire logic        i_host_bus_fatal_irq_enable,
  input  wire logic        i_host_bus_data_irq_enable,
  input  wire logic        i_if_fatal_irq_enable,
  input  wire logic        i_if_nonfatal_irq_enable,
  input  wire logic        i_pm_irq_enable,
  input  wire logic        i_taskfile_error_irq_enable,
  input  wire logic        i_fbs_enable,
  input  wire logic [5:0]  i_status_clr,
  input  wire logic [3:0]  i_link_error_clr,
  input  wire logic        i_single_drive_error_clr,
  input  wire logic        i_mem_abort,
  input  wire logic        i_mem_data_err,
  input  wire logic [2:0]  i_mem_err_src,
  input  wire logic        i_xfer_active,
  input  wire logic        i_abort_done,
  input  wire logic        i_link_ready_indication,
  input  wire logic        i_rx_sof,
  input  wire logic        i_rx_eof,
  input  wire logic        i_rx_is_data,
  input  wire logic        i_rx_ctrl_disp_err,
  input  wire logic        i_rx_data_char_err,
  input  wire logic        i_rx_crc_bad,
  input  wire logic        i_rx_type_known,
  input  wire logic        i_rx_content_bad,
  input  wire logic [13:0] i_rx_len,
  input  wire logic        i_rx_fifo_overflow,
  input  wire logic [3:0]  i_rx_multiplier_port_field,
  input  wire logic        i_pm_attached,
  input  wire logic [15:0] i_pmp_expected,
  input  wire logic        i_rx_updates_taskfile,
  input  wire logic        i_rx_updates_bsy_drq,
  input  wire logic        i_rx_sets_err,
  input  wire logic        i_rx_is_device_bits_frame,
  input  wire logic        i_rx_is_reg_or_setup,
  input  wire logic [31:0] i_rx_sactive,
  input  wire logic        i_taskfile_busy_flag,
  input  wire logic        i_taskfile_transfer_request_flag,
  input  wire logic        i_tx_active,
  input  wire logic        i_tx_is_data,
  input  wire logic        i_tx_rerr,
  input  wire logic        i_tx_ok,
  output logic             o_abort_req,
  output logic             o_halt,
  output logic             o_crc_poison,
  output logic             o_disp_reset,
  output logic             o_link_to_idle,
  output logic             o_rx_reply_rok,
  output logic             o_rx_reply_rerr,
  output logic             o_rx_post,
  output logic             o_rx_discard,
  output logic             o_tx_retry,
  output logic             o_retry_pending,
  output logic             o_host_bus_fatal_status,
  output logic             o_host_bus_data_error_status,
  output logic             o_fatal_interface_error_status,
  output logic             o_nonfatal_interface_error_status,
  output logic             o_port_multiplier_error_status,
  output logic             o_taskfile_error_status,
  output logic [3:0]       o_link_error_register,
  output logic             o_taskfile_error_flag,
  output logic [31:0]      o_active_tag_register,
  output logic [3:0]       o_failing_drive_field,
  output logic             o_single_drive_error_flag,
  output logic             o_irq
);

  spe_pkg::spe_abt_e abt_reg;
  logic              abt_fatal_reg;
  logic              in_frame_reg;
  logic              rx_data_reg;
  logic              dec_err_reg;
  logic              ovf_reg;
  logic              ready_reg;
  logic [5:0]        status_reg;
  logic [5:0]        status_next;
  logic [5:0]        st_set;
  logic [5:0]        st_en;
  logic [3:0]        le_reg;
  logic [3:0]        le_set;
  logic [1:0]        if_cls;
  logic              eof_w;
  logic              dec_any;
  logic              ovf_any;
  logic              illegal;
  logic              rx_bad;
  logic              pmp_bad;
  logic              ignore_frm;
  logic              accept;
  logic              link_drop;
  logic              tf_upd;
  logic              tfe_set;
  logic              fetch_err;
  logic              data_err;
  logic              fail_nd;

  // Frame tracking and error latches
  assign eof_w = i_rx_eof && in_frame_reg;
  assign dec_any = dec_err_reg || (i_rx_data_char_err && in_frame_reg);
  assign ovf_any = ovf_reg || (i_rx_fifo_overflow && in_frame_reg);
  assign illegal = i_rx_type_known ? i_rx_content_bad : (i_rx_len > spe_pkg::UNK_MAX_LEN); // [RULE14]
  assign rx_bad = i_rx_crc_bad || illegal || ovf_any || dec_any;
  assign pmp_bad = i_pm_attached && !i_pmp_expected[i_rx_multiplier_port_field];
  assign ignore_frm = i_rx_updates_bsy_drq && !i_taskfile_busy_flag
                      && !i_taskfile_transfer_request_flag; // [RULE17]
  assign accept = eof_w && !rx_bad && !pmp_bad && !ignore_frm;
  assign link_drop = ready_reg && !i_link_ready_indication;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      in_frame_reg <= 1'b0;
      rx_data_reg  <= 1'b0;
      ready_reg    <= 1'b0;
    end
    else
    begin
      ready_reg <= i_link_ready_indication;
      if (!i_link_ready_indication || i_rx_eof)
        in_frame_reg <= 1'b0;
      else if (i_rx_sof)
        in_frame_reg <= 1'b1;
      if (i_rx_sof)
        rx_data_reg <= i_rx_is_data;
    end
  end

  // Outside a frame these events are dropped on purpose
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      dec_err_reg <= 1'b0;
      ovf_reg     <= 1'b0;
    end
    else if (i_rx_sof || i_rx_eof || !i_link_ready_indication)
    begin
      dec_err_reg <= 1'b0;
      ovf_reg     <= 1'b0;
    end
    else
    begin
      dec_err_reg <= dec_any; // [RULE11]
      ovf_reg     <= ovf_any; // [RULE15]
    end
  end

  // Frame-end replies and link-side pulses
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rx_reply_rok  <= 1'b0;
      o_rx_reply_rerr <= 1'b0;
      o_rx_post       <= 1'b0;
      o_rx_discard    <= 1'b0;
      o_link_to_idle  <= 1'b0;
      o_disp_reset    <= 1'b0;
    end
    else
    begin
      o_rx_reply_rerr <= eof_w && rx_bad; // [RULE11] [RULE13] [RULE14] [RULE15]
      o_rx_reply_rok  <= eof_w && !rx_bad; // [RULE17] [RULE19]
      // Data frames stream to memory; only non-Data waits here
      o_rx_post       <= accept && !rx_data_reg; // [RULE18]
      o_rx_discard    <= eof_w && !accept; // [RULE14] [RULE19]
      o_link_to_idle  <= link_drop || (eof_w && (i_rx_crc_bad || illegal)); // [RULE12] [RULE13]
      o_disp_reset    <= i_rx_ctrl_disp_err; // [RULE10]
    end
  end

  // Link error register, set wins over clear
  always_comb
  begin
    le_set        = '0;
    le_set[spe_pkg::LE_P] = eof_w && (illegal || ovf_any); // [RULE14] [RULE15]
    le_set[spe_pkg::LE_C] = eof_w && i_rx_crc_bad; // [RULE13]
    le_set[spe_pkg::LE_H] = i_tx_rerr; // [RULE16]
    le_set[spe_pkg::LE_B] = eof_w && dec_any; // [RULE11]
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      le_reg <= spe_pkg::LE_RST;
    else
      le_reg <= (le_reg & ~i_link_error_clr) | le_set;
  end

  // Interface error class; decode error alone flags nothing
  always_comb
  begin
    if_cls = 2'b00;
    if (eof_w && (i_rx_crc_bad || illegal || ovf_any))
      if_cls = if_cls | spe_pkg::spe_classify(rx_data_reg); // [RULE6] [RULE7]
    if (i_tx_rerr)
      if_cls = if_cls | spe_pkg::spe_classify(i_tx_is_data); // [RULE6] [RULE7]
    if (link_drop && (in_frame_reg || i_tx_active))
      if_cls = if_cls | spe_pkg::spe_classify(in_frame_reg ? rx_data_reg : i_tx_is_data); // [RULE12]
  end

  // Memory abort sequencing
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      abt_reg       <= spe_pkg::SPE_ABT_IDLE;
      abt_fatal_reg <= 1'b0;
    end
    else
    begin
      case (abt_reg)
        spe_pkg::SPE_ABT_IDLE:
          if (i_mem_abort || i_mem_data_err)
          begin
            abt_fatal_reg <= i_mem_abort;
            abt_reg <= i_xfer_active ? spe_pkg::SPE_ABT_WAIT : spe_pkg::SPE_ABT_SET;
          end
        spe_pkg::SPE_ABT_WAIT:
          if (i_abort_done)
            abt_reg <= spe_pkg::SPE_ABT_SET; // [RULE1] [RULE5]
        spe_pkg::SPE_ABT_SET:
          abt_reg <= spe_pkg::SPE_ABT_IDLE;
        default:
          abt_reg <= spe_pkg::SPE_ABT_IDLE;
      endcase
    end
  end

  assign o_abort_req = (abt_reg == spe_pkg::SPE_ABT_WAIT);

  // Taskfile and device-bits handling
  assign tf_upd = accept && i_rx_updates_taskfile;
  assign tfe_set = tf_upd && i_rx_sets_err && (i_rx_is_device_bits_frame || i_rx_is_reg_or_setup);

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_taskfile_error_flag <= 1'b0;
      o_active_tag_register <= spe_pkg::SACT_RST;
    end
    else
    begin
      if (tf_upd)
        o_taskfile_error_flag <= i_rx_sets_err;
      if (accept && i_rx_is_device_bits_frame)
        o_active_tag_register <= i_rx_sactive; // [RULE21]
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_failing_drive_field     <= spe_pkg::DRIVE_RST;
      o_single_drive_error_flag <= 1'b0;
    end
    else if (tfe_set && i_fbs_enable)
    begin
      o_failing_drive_field     <= i_rx_multiplier_port_field; // [RULE21] [RULE22]
      o_single_drive_error_flag <= 1'b1;
    end
    else if (i_single_drive_error_clr)
      o_single_drive_error_flag <= 1'b0;
  end

  // Halt and poison, released by clearing the start bit
  assign fetch_err = i_mem_data_err && (i_mem_err_src == spe_pkg::MSRC_CMD_LIST
                     || i_mem_err_src == spe_pkg::MSRC_CMD_FRM
                     || i_mem_err_src == spe_pkg::MSRC_SG_ENTRY);
  assign data_err = i_mem_data_err && (i_mem_err_src == spe_pkg::MSRC_DATA
                    || i_mem_err_src == spe_pkg::MSRC_ATAPI);

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_halt <= 1'b0;
    else if (fetch_err // [RULE3]
             || if_cls[1] // [RULE9]
             || (tfe_set && i_rx_is_reg_or_setup && !i_fbs_enable) // [RULE22]
             || (tf_upd && i_rx_sets_err && i_taskfile_error_irq_enable)) // [RULE20]
      o_halt <= 1'b1;
    else if (!i_port_start_bit)
      o_halt <= 1'b0;
  end

  // This design keeps running after a data error, so poison instead
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_crc_poison <= 1'b0;
    else if (data_err && i_port_start_bit)
      o_crc_poison <= 1'b1; // [RULE4]
    else if (!i_port_start_bit)
      o_crc_poison <= 1'b0;
  end

  // Status bits and interrupt
  always_comb
  begin
    st_set                  = '0;
    st_set[spe_pkg::ST_HBF] = (abt_reg == spe_pkg::SPE_ABT_SET) && abt_fatal_reg; // [RULE1]
    st_set[spe_pkg::ST_HBD] = (abt_reg == spe_pkg::SPE_ABT_SET) && !abt_fatal_reg; // [RULE5]
    st_set[spe_pkg::ST_IF]  = if_cls[1]; // [RULE6]
    st_set[spe_pkg::ST_INF] = if_cls[0]; // [RULE6]
    st_set[spe_pkg::ST_PM]  = eof_w && !rx_bad && pmp_bad; // [RULE19]
    st_set[spe_pkg::ST_TFE] = tfe_set; // [RULE21] [RULE22]
  end

  assign status_next = (status_reg & ~i_status_clr) | st_set;
  assign st_en = {i_taskfile_error_irq_enable, i_pm_irq_enable, i_if_nonfatal_irq_enable,
                  i_if_fatal_irq_enable, i_host_bus_data_irq_enable, i_host_bus_fatal_irq_enable};

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_reg <= spe_pkg::ST_RST;
      o_irq      <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      o_irq      <= i_global_interrupt_enable && |(status_next & st_en); // [RULE2] [RULE20] [RULE23]
    end
  end

  assign o_host_bus_fatal_status          = status_reg[spe_pkg::ST_HBF];
  assign o_host_bus_data_error_status     = status_reg[spe_pkg::ST_HBD];
  assign o_fatal_interface_error_status   = status_reg[spe_pkg::ST_IF];
  assign o_nonfatal_interface_error_status = status_reg[spe_pkg::ST_INF];
  assign o_port_multiplier_error_status   = status_reg[spe_pkg::ST_PM];
  assign o_taskfile_error_status          = status_reg[spe_pkg::ST_TFE];
  assign o_link_error_register            = le_reg;

  // Retry of failed non-Data frames
  assign fail_nd = (i_tx_rerr || (link_drop && i_tx_active)) && !i_tx_is_data;

  spe_retry_ctl u_retry
  (
    .i_clk_sys      (i_clk_sys),
    .i_rst          (i_rst),
    .i_port_start   (i_port_start_bit),
    .i_fail_nondata (fail_nd),
    .i_tx_ok        (i_tx_ok),
    .i_rx_busy      (in_frame_reg || i_rx_sof || o_rx_post),
    .o_retry        (o_tx_retry),
    .o_pending      (o_retry_pending)
  );

  property p_hbf_after_done;
    @(posedge i_clk_sys) disable iff (i_rst)
    (abt_reg == spe_pkg::SPE_ABT_WAIT && i_abort_done && abt_fatal_reg) |-> ##2 o_host_bus_fatal_status;
  endproperty
  a_hbf_after_done: assert property (p_hbf_after_done) else $error("fatal status late"); // [RULE1]

  property p_hbf_irq;
    @(posedge i_clk_sys) disable iff (i_rst)
    (status_reg[spe_pkg::ST_HBF] && !i_status_clr[spe_pkg::ST_HBF] && i_host_bus_fatal_irq_enable
      && i_global_interrupt_enable) |=> o_irq;
  endproperty
  a_hbf_irq: assert property (p_hbf_irq) else $error("missing fatal interrupt"); // [RULE2]

  property p_fetch_halt;
    @(posedge i_clk_sys) disable iff (i_rst)
    fetch_err |=> o_halt;
  endproperty
  a_fetch_halt: assert property (p_fetch_halt) else $error("fetch error did not halt"); // [RULE3]

  property p_poison;
    @(posedge i_clk_sys) disable iff (i_rst)
    (data_err && i_port_start_bit) |=> o_crc_poison [*2];
  endproperty
  a_poison: assert property (p_poison) else $error("CRC not poisoned"); // [RULE4]

  property p_nd_nonfatal;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_tx_rerr && !i_tx_is_data) |=> o_nonfatal_interface_error_status && o_link_error_register[spe_pkg::LE_H];
  endproperty
  a_nd_nonfatal: assert property (p_nd_nonfatal) else $error("non-Data failure misclassified"); // [RULE7]

  property p_k283;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_rx_ctrl_disp_err |=> o_disp_reset;
  endproperty
  a_k283: assert property (p_k283) else $error("decoder disparity not reset"); // [RULE10]

  property p_decode_only;
    @(posedge i_clk_sys) disable iff (i_rst)
    (eof_w && dec_any && !i_rx_crc_bad && !illegal && !ovf_any && !i_tx_rerr && !link_drop
      && i_status_clr == 6'h00) |=> o_rx_reply_rerr && $stable(status_reg);
  endproperty
  a_decode_only: assert property (p_decode_only) else $error("decode error set status"); // [RULE11]

  property p_crc;
    @(posedge i_clk_sys) disable iff (i_rst)
    (eof_w && i_rx_crc_bad) |=> o_rx_reply_rerr && o_link_to_idle && o_link_error_register[spe_pkg::LE_C];
  endproperty
  a_crc: assert property (p_crc) else $error("CRC error handling wrong"); // [RULE13]

  property p_ignore;
    @(posedge i_clk_sys) disable iff (i_rst)
    (eof_w && ignore_frm && !rx_bad) |=> o_rx_reply_rok && !o_rx_post;
  endproperty
  a_ignore: assert property (p_ignore) else $error("idle-status frame not ignored"); // [RULE17]

  property p_pmp;
    @(posedge i_clk_sys) disable iff (i_rst)
    (eof_w && pmp_bad && !rx_bad) |=> o_rx_reply_rok && o_rx_discard && o_port_multiplier_error_status;
  endproperty
  a_pmp: assert property (p_pmp) else $error("multiplier port mismatch missed"); // [RULE19]

  c_abort: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_abort_req ##[1:20] o_host_bus_fatal_status);
  c_retry: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_retry_pending ##[1:20] o_tx_retry);
  c_tfe:   cover property (@(posedge i_clk_sys) disable iff (i_rst) tfe_set ##1 o_irq);

endmodule : spe_err_classifier

`default_nettype wire

// ==== verification/spe_drive_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module spe_drive_model
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_send,
  input  wire logic       i_resend,
  input  wire logic [1:0] i_fails,
  input  wire logic [3:0] i_dly,
  output logic            o_tx_rerr,
  output logic            o_tx_ok
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] left = 2'h0;

  initial o_tx_rerr = 1'b0;
  initial o_tx_ok = 1'b0;

  // First i_fails answers are refusals
  always @(negedge i_clk_sys)
  begin
    o_tx_rerr <= (cnt == 4'h1) && (left != 2'h0);
    o_tx_ok   <= (cnt == 4'h1) && (left == 2'h0);
    if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if ((cnt == 4'h1) && (left != 2'h0))
      left <= left - 2'h1;
    if (i_send || i_resend)
      cnt <= i_dly;
    if (i_send)
      left <= i_fails;
  end
endmodule : spe_drive_model

`default_nettype wire

// ==== verification/spe_err_classifier_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module spe_err_classifier_tb;
  logic        i_clk_sys = 0, i_rst = 1, i_port_start_bit = 1, i_global_interrupt_enable = 0, i_fbs_enable = 0;
  logic        i_host_bus_fatal_irq_enable = 1, i_host_bus_data_irq_enable = 1, i_if_fatal_irq_enable = 1;
  logic        i_if_nonfatal_irq_enable = 1, i_pm_irq_enable = 1, i_taskfile_error_irq_enable = 0, i_pm_attached = 1;
  logic        i_single_drive_error_clr = 0, i_mem_abort = 0, i_mem_data_err = 0, i_xfer_active = 0, i_abort_done = 0;
  logic        i_link_ready_indication = 1, i_rx_sof = 0, i_rx_eof = 0, i_rx_is_data = 0, i_rx_ctrl_disp_err = 0;
  logic        i_rx_data_char_err = 0, i_rx_crc_bad = 0, i_rx_type_known = 1, i_rx_content_bad = 0;
  logic        i_rx_fifo_overflow = 0, i_rx_updates_taskfile = 0, i_rx_updates_bsy_drq = 0, i_rx_sets_err = 0;
  logic        i_rx_is_device_bits_frame = 0, i_rx_is_reg_or_setup = 0, i_taskfile_busy_flag = 0;
  logic        i_taskfile_transfer_request_flag = 0, i_tx_active = 0, i_tx_is_data = 0, i_tx_rerr, i_tx_ok, send = 0;
  logic [1:0]  fails = 2'h0;
  logic [2:0]  i_mem_err_src = 3'h0;
  logic [3:0]  i_link_error_clr = 4'h0, i_rx_multiplier_port_field = 4'h3, dly = 4'h2;
  logic [5:0]  i_status_clr = 6'h00;
  logic [13:0] i_rx_len = 14'h0014;
  logic [15:0] i_pmp_expected = 16'h0008;
  logic [31:0] i_rx_sactive = 32'h0000_0000;
  logic        o_abort_req, o_halt, o_crc_poison, o_disp_reset, o_link_to_idle, o_rx_reply_rok, o_rx_reply_rerr;
  logic        o_rx_post, o_rx_discard, o_tx_retry, o_retry_pending, o_host_bus_fatal_status;
  logic        o_host_bus_data_error_status, o_fatal_interface_error_status, o_nonfatal_interface_error_status;
  logic        o_port_multiplier_error_status, o_taskfile_error_status, o_taskfile_error_flag;
  logic        o_single_drive_error_flag, o_irq;
  logic [3:0]  o_link_error_register, o_failing_drive_field;
  logic [31:0] o_active_tag_register;
  int          fail_count = 0, checks = 0, n;
  wire  [5:0]  st = {o_taskfile_error_status, o_port_multiplier_error_status, o_nonfatal_interface_error_status,
                     o_fatal_interface_error_status, o_host_bus_data_error_status, o_host_bus_fatal_status};
  wire  [3:0]  rep = {o_rx_reply_rok, o_rx_reply_rerr, o_rx_post, o_rx_discard};

  spe_err_classifier i_spe_err_classifier (.*);
  spe_drive_model i_spe_drive_model (.i_clk_sys(i_clk_sys), .i_send(send), .i_resend(o_tx_retry), .i_fails(fails),
                                     .i_dly(dly), .o_tx_rerr(i_tx_rerr), .o_tx_ok(i_tx_ok));

  always #2.5 i_clk_sys = ~i_clk_sys;

  task automatic tick();
    @(negedge i_clk_sys);
  endtask : tick

  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic clr();
    i_status_clr = 6'h3f;
    i_link_error_clr = 4'hf;
    tick();
    i_status_clr = 6'h00;
    i_link_error_clr = 4'h0;
    tick();
  endtask : clr

  // Decode fault lands mid-frame
  task automatic rxc(input logic dat, crc, kn, dec, bsy, input logic [13:0] len, input logic [3:0] multiplier_port_field,
                     input logic [3:0] rep_x, input logic [5:0] st_x, input logic [3:0] le_x);
    i_rx_sof = 1;
    i_rx_is_data = dat;
    tick();
    i_rx_sof = 0;
    i_rx_data_char_err = dec;
    tick();
    i_rx_data_char_err = 0;
    i_rx_eof = 1;
    i_rx_crc_bad = crc;
    i_rx_type_known = kn;
    i_rx_len = len;
    i_rx_multiplier_port_field = multiplier_port_field;
    i_rx_updates_bsy_drq = bsy;
    tick();
    i_rx_eof = 0;
    chk("reply", rep, rep_x);
    chk("status", st, st_x);
    chk("link errors", o_link_error_register, le_x);
    clr();
  endtask : rxc

  task automatic wait_st(input logic [5:0] x);
    for (n = 0; n < 40 && st !== x; n++)
      tick();
    chk("status", st, x);
    if (st !== x)
      test_done();
  endtask : wait_st

  initial
  begin
    repeat (10) tick();
    i_rst = 0;
    tick();
    i_xfer_active = 1;
    i_mem_abort = 1;
    tick();
    i_mem_abort = 0;
    chk("abort request", o_abort_req, 1'b1);
    repeat (2) tick();
    chk("status before end", st, 6'h00);
    i_abort_done = 1;
    tick();
    i_abort_done = 0;
    i_xfer_active = 0;
    tick();
    chk("fatal status", st, 6'h01);
    chk("irq without global enable", o_irq, 1'b0);
    i_global_interrupt_enable = 1;
    tick();
    chk("fatal irq", o_irq, 1'b1);
    clr();
    for (int s = 0; s < 5; s++)
    begin
      i_mem_data_err = 1;
      i_mem_err_src = 3'(s);
      tick();
      i_mem_data_err = 0;
      tick();
      chk("data error status", st, 6'h02);
      chk("irq", o_irq, 1'b1);
      chk("halt", o_halt, s < 3);
      chk("poison", o_crc_poison, s >= 3);
      i_port_start_bit = 0;
      clr();
      i_port_start_bit = 1;
      chk("irq cleared", o_irq, 1'b0);
    end
    rxc(0, 1, 1, 0, 0, 14'h14, 4'h3, 4'b0101, 6'h08, 4'h2);
    rxc(0, 0, 1, 1, 0, 14'h14, 4'h3, 4'b0101, 6'h00, 4'h8);
    rxc(0, 0, 0, 0, 0, 14'h40, 4'h3, 4'b1010, 6'h00, 4'h0);
    rxc(0, 0, 0, 0, 0, 14'h41, 4'h3, 4'b0101, 6'h08, 4'h1);
    rxc(0, 0, 1, 0, 0, 14'h14, 4'h5, 4'b1001, 6'h10, 4'h0);
    rxc(0, 0, 1, 0, 1, 14'h14, 4'h3, 4'b1001, 6'h00, 4'h0);
    rxc(1, 1, 1, 0, 0, 14'h14, 4'h3, 4'b0101, 6'h04, 4'h2);
    i_rx_ctrl_disp_err = 1;
    tick();
    i_rx_ctrl_disp_err = 0;
    chk("decoder reset", o_disp_reset, 1'b1);
    chk("link errors", o_link_error_register, 4'h0);
    i_link_ready_indication = 0;
    tick();
    chk("to idle", o_link_to_idle, 1'b1);
    chk("status", st, 6'h00);
    i_link_ready_indication = 1;
    i_port_start_bit = 0;
    tick();
    i_port_start_bit = 1;
    i_tx_active = 1;
    fails = 2'h2;
    dly = 4'h6;
    send <= 1;
    tick();
    send <= 0;
    wait_st(6'h08);
    chk("link errors", o_link_error_register, 4'h4);
    for (n = 0; n < 60 && o_retry_pending !== 1'b0; n++)
      tick();
    chk("pending", o_retry_pending, 1'b0);
    clr();
    i_tx_is_data = 1;
    fails = 2'h1;
    dly = 4'h2;
    send <= 1;
    tick();
    send <= 0;
    wait_st(6'h04);
    repeat (3) tick();
    chk("halt", o_halt, 1'b1);
    chk("no data resend", o_retry_pending, 1'b0);
    i_tx_active = 0;
    i_port_start_bit = 0;
    clr();
    i_port_start_bit = 1;
    i_fbs_enable = 1;
    i_rx_is_device_bits_frame = 1;
    i_rx_sets_err = 1;
    i_rx_updates_taskfile = 1;
    i_rx_sactive = 32'h0000_0101;
    rxc(0, 0, 1, 0, 0, 14'h08, 4'h3, 4'b1010, 6'h20, 4'h0);
    chk("active tags", o_active_tag_register, 32'h0000_0101);
    chk("failing drive", o_failing_drive_field, 4'h3);
    chk("single drive flag", o_single_drive_error_flag, 1'b1);
    i_fbs_enable = 0;
    i_rx_is_device_bits_frame = 0;
    i_rx_is_reg_or_setup = 1;
    i_taskfile_error_irq_enable = 1;
    rxc(0, 0, 1, 0, 0, 14'h14, 4'h3, 4'b1010, 6'h20, 4'h0);
    chk("halt", o_halt, 1'b1);
    chk("tf flag", o_taskfile_error_flag, 1'b1);
    test_done();
  end
endmodule : spe_err_classifier_tb

`default_nettype wire
